// File: rtl/pin_function_ctrl_reg_pkg.sv
// Package for the serial port control register block.
// Assumes one 20 MHz clock and an 8-bit register port.
package pin_function_ctrl_reg_pkg;

  // Register indices on the plain register port
  localparam logic [2:0] ADDR_CTRL   = 3'h0;
  localparam logic [2:0] ADDR_TXDATA = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_IRQST  = 3'h3;
  localparam logic [2:0] ADDR_IRQMSK = 3'h4;

  // Values after reset
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [7:0] STATUS_RST  = 8'h84;
  localparam logic [3:0] IRQ_RST     = 4'h0;

  // Status bit positions
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_RX_FULL  = 6;
  localparam int ST_OVERRUN  = 5;
  localparam int ST_FRAMING  = 4;
  localparam int ST_PARITY   = 3;
  localparam int ST_TX_END   = 2;

  // Event bit positions in the interrupt status register
  localparam int EV_TX_EMPTY = 0;
  localparam int EV_RX_FULL  = 1;
  localparam int EV_RX_ERROR = 2;
  localparam int EV_TX_END   = 3;
  localparam int EV_COUNT    = 4;

  // Clock select codes
  localparam logic [1:0] CKSEL_INT     = 2'h0;
  localparam logic [1:0] CKSEL_INT_OUT = 2'h1;
  localparam logic [1:0] CKSEL_EXT     = 2'h2;

  typedef struct packed {
    logic       tx_irq_enable;
    logic       rx_irq_enable;
    logic       transmit_enable;
    logic       receive_enable;
    logic       reserved_bit3;
    logic       tx_end_irq_enable;
    logic       clock_select_hi;
    logic       clock_select_lo;
  } pin_function_ctrl_reg_ctrl_t;

  typedef struct packed {
    logic       tx_empty_flag;
    logic       rx_full_flag;
    logic       overrun_error_flag;
    logic       framing_error_flag;
    logic       parity_error_flag;
    logic       tx_end_flag;
    logic [1:0] unused;
  } pin_function_ctrl_reg_stat_t;

endpackage

// File: rtl/pin_function_ctrl_reg_top.sv
// Serial control register, status flags and interrupt requests.
// Assumes the shift datapath runs on mclk_i and the clock pin is async.
//
// Summary of operation
// R1 - Control clears on reset and low power
// R2 - Bit 7 enables transmit empty request
// R3 - Bit 6 enables receive full, error
// R4 - Flag or enable clear drops receive requests
// R5 - Transmit enable off holds empty flag set
// R6 - Data write clears empty, starts transmission
// R7 - Software sets format before transmit enable
// R8 - Bit 4 enables reception on start
// R9 - Software sets format before receive enable
// R10 - Receive disable keeps receive flags
// R11 - Bit 2 enables transmit end request
// R12 - End request drops on flags or enable
// R13 - Async 00: internal clock, pin is port
// R14 - Async 01: internal, bit clock out
// R15 - Async external: pin gives 16x clock
// R16 - Sync 00: internal clock driven out
// R17 - Sync 10: clock pin is input
// R18 - Software avoids reserved codes and bit 3
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module pin_function_ctrl_reg_top (
  input  wire logic       mclk_i,
  input  wire logic       reset_i,
  input  wire logic       low_power_i,
  input  wire logic       sync_mode_i,
  input  wire logic [2:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  input  wire logic       tx_load_i,
  input  wire logic       tx_done_i,
  input  wire logic       rx_done_i,
  input  wire logic       rx_frame_err_i,
  input  wire logic       rx_parity_err_i,
  input  wire logic       rx_data_read_i,
  input  wire logic       bit_clk_i,
  input  wire logic       serial_clock_pin_i,
  output logic            serial_clock_pin_o,
  output logic            serial_clock_pin_oe_o,
  output logic            ext_clk_sel_o,
  output logic            ext_clk_o,
  output logic            tx_start_o,
  output logic      [7:0] tx_data_o,
  output logic            transmit_enable_o,
  output logic            receive_enable_o,
  output logic            tx_empty_irq_o,
  output logic            rx_full_irq_o,
  output logic            rx_error_irq_o,
  output logic            tx_end_irq_o,
  output logic            irq_o
);

  function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
    hit = (a == r);
  endfunction

  pin_function_ctrl_reg_pkg::pin_function_ctrl_reg_ctrl_t   ctrl_q;
  pin_function_ctrl_reg_pkg::pin_function_ctrl_reg_ctrl_t   ctrl_d;
  pin_function_ctrl_reg_pkg::pin_function_ctrl_reg_stat_t   stat_q;
  pin_function_ctrl_reg_pkg::pin_function_ctrl_reg_stat_t   stat_d;
  logic [3:0]             ev_q;
  logic [3:0]             ev_d;
  logic [3:0]             mask_q;
  logic [3:0]             req_q;
  logic [3:0]             req_d;
  logic [3:0]             req_prev_q;
  logic                   sck_s1_q;
  logic                   sck_s2_q;
  logic [7:0]             rdata_d;

  // Register port decode
  wire wr_ctrl   = reg_wr_i & hit(reg_addr_i, pin_function_ctrl_reg_pkg::ADDR_CTRL);
  wire wr_txdata = reg_wr_i & hit(reg_addr_i, pin_function_ctrl_reg_pkg::ADDR_TXDATA);
  wire wr_status = reg_wr_i & hit(reg_addr_i, pin_function_ctrl_reg_pkg::ADDR_STATUS);
  wire wr_irqst  = reg_wr_i & hit(reg_addr_i, pin_function_ctrl_reg_pkg::ADDR_IRQST);
  wire wr_irqmsk = reg_wr_i & hit(reg_addr_i, pin_function_ctrl_reg_pkg::ADDR_IRQMSK);

  // Control register next value
  assign ctrl_d = low_power_i ? pin_function_ctrl_reg_pkg::pin_function_ctrl_reg_ctrl_t'(pin_function_ctrl_reg_pkg::CTRL_RST)
                : wr_ctrl ? pin_function_ctrl_reg_pkg::pin_function_ctrl_reg_ctrl_t'(reg_wdata_i)
                : ctrl_q; // R1

  // Software clears a status flag by writing zero to it
  wire clr_tx_empty_flag = wr_status & ~reg_wdata_i[pin_function_ctrl_reg_pkg::ST_TX_EMPTY];
  wire clr_rx_full_flag = wr_status & ~reg_wdata_i[pin_function_ctrl_reg_pkg::ST_RX_FULL];
  wire clr_oer  = wr_status & ~reg_wdata_i[pin_function_ctrl_reg_pkg::ST_OVERRUN];
  wire clr_fer  = wr_status & ~reg_wdata_i[pin_function_ctrl_reg_pkg::ST_FRAMING];
  wire clr_per  = wr_status & ~reg_wdata_i[pin_function_ctrl_reg_pkg::ST_PARITY];
  wire clr_tx_end_flag = wr_status & ~reg_wdata_i[pin_function_ctrl_reg_pkg::ST_TX_END];

  // Transmit data write only starts a transfer while enabled
  wire tx_go    = wr_txdata & ctrl_q.transmit_enable; // R6
  wire overrun  = rx_done_i & stat_q.rx_full_flag;
  wire rx_ok    = rx_done_i & ~stat_q.rx_full_flag
                & ~rx_frame_err_i & ~rx_parity_err_i;

  // Receive flags never look at receive enable
  assign stat_d.rx_full_flag = rx_ok
    | (stat_q.rx_full_flag & ~clr_rx_full_flag & ~rx_data_read_i); // R10
  assign stat_d.overrun_error_flag = overrun
    | (stat_q.overrun_error_flag & ~clr_oer); // R10
  assign stat_d.framing_error_flag = (rx_done_i & rx_frame_err_i)
    | (stat_q.framing_error_flag & ~clr_fer); // R10
  assign stat_d.parity_error_flag = (rx_done_i & rx_parity_err_i)
    | (stat_q.parity_error_flag & ~clr_per); // R10

  // Empty flag is held at one while transmit is disabled
  assign stat_d.tx_empty_flag = ~ctrl_q.transmit_enable | tx_load_i
    | (stat_q.tx_empty_flag & ~clr_tx_empty_flag & ~tx_go); // R5 R6
  assign stat_d.tx_end_flag = tx_done_i
    | (stat_q.tx_end_flag & ~clr_tx_end_flag & ~tx_go);
  assign stat_d.unused = 2'h0;

  // Request levels
  wire rx_err_any = stat_q.overrun_error_flag
                  | stat_q.framing_error_flag
                  | stat_q.parity_error_flag;
  assign req_d[pin_function_ctrl_reg_pkg::EV_TX_EMPTY] =
    ctrl_q.tx_irq_enable & stat_q.tx_empty_flag; // R2
  assign req_d[pin_function_ctrl_reg_pkg::EV_RX_FULL] =
    ctrl_q.rx_irq_enable & stat_q.rx_full_flag; // R3 R4
  assign req_d[pin_function_ctrl_reg_pkg::EV_RX_ERROR] =
    ctrl_q.rx_irq_enable & rx_err_any; // R3 R4
  assign req_d[pin_function_ctrl_reg_pkg::EV_TX_END] =
    ctrl_q.tx_end_irq_enable & stat_q.tx_end_flag; // R11 R12

  // Sticky events on rising request, set wins over clear
  genvar gi;
  generate
    for (gi = 0; gi < pin_function_ctrl_reg_pkg::EV_COUNT; gi++) begin : g_ev
      assign ev_d[gi] = (req_q[gi] & ~req_prev_q[gi])
                      | (ev_q[gi] & ~(wr_irqst & reg_wdata_i[gi]));
    end
  endgenerate

  // Clock source selection
  wire [1:0] cksel = {ctrl_q.clock_select_hi, ctrl_q.clock_select_lo};
  wire sel_ext  = (cksel == pin_function_ctrl_reg_pkg::CKSEL_EXT); // R15 R17
  wire drive_ck = sync_mode_i ? (cksel == pin_function_ctrl_reg_pkg::CKSEL_INT)
                : (cksel == pin_function_ctrl_reg_pkg::CKSEL_INT_OUT); // R13 R14 R16

  // Read data mux
  assign rdata_d =
      ~reg_rd_i ? 8'h00
    : hit(reg_addr_i, pin_function_ctrl_reg_pkg::ADDR_CTRL)   ? 8'(ctrl_q)
    : hit(reg_addr_i, pin_function_ctrl_reg_pkg::ADDR_STATUS) ? 8'(stat_q)
    : hit(reg_addr_i, pin_function_ctrl_reg_pkg::ADDR_IRQST)  ? {4'h0, ev_q}
    : hit(reg_addr_i, pin_function_ctrl_reg_pkg::ADDR_IRQMSK) ? {4'h0, mask_q}
    : 8'h00;

  // Serial clock pin synchroniser
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
    end else begin
      sck_s1_q <= serial_clock_pin_i;
      sck_s2_q <= sck_s1_q;
    end
  end

  // Control and status state
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_q <= pin_function_ctrl_reg_pkg::pin_function_ctrl_reg_ctrl_t'(pin_function_ctrl_reg_pkg::CTRL_RST); // R1
      stat_q <= pin_function_ctrl_reg_pkg::pin_function_ctrl_reg_stat_t'(pin_function_ctrl_reg_pkg::STATUS_RST);
    end else begin
      ctrl_q <= ctrl_d;
      stat_q <= low_power_i
              ? pin_function_ctrl_reg_pkg::pin_function_ctrl_reg_stat_t'(pin_function_ctrl_reg_pkg::STATUS_RST) : stat_d;
    end
  end

  // Interrupt state
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ev_q       <= pin_function_ctrl_reg_pkg::IRQ_RST;
      mask_q     <= pin_function_ctrl_reg_pkg::IRQ_RST;
      req_q      <= pin_function_ctrl_reg_pkg::IRQ_RST;
      req_prev_q <= pin_function_ctrl_reg_pkg::IRQ_RST;
      irq_o      <= 1'b0;
    end else begin
      ev_q       <= ev_d;
      mask_q     <= wr_irqmsk ? reg_wdata_i[3:0] : mask_q;
      req_q      <= req_d;
      req_prev_q <= req_q;
      irq_o      <= |(ev_d & (wr_irqmsk ? reg_wdata_i[3:0] : mask_q));
    end
  end

  // Registered outputs
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o           <= 8'h00;
      tx_start_o            <= 1'b0;
      tx_data_o             <= 8'h00;
      transmit_enable_o     <= 1'b0;
      receive_enable_o      <= 1'b0;
      serial_clock_pin_o    <= 1'b0;
      serial_clock_pin_oe_o <= 1'b0;
      ext_clk_sel_o         <= 1'b0;
      ext_clk_o             <= 1'b0;
    end else begin
      reg_rdata_o           <= rdata_d;
      tx_start_o            <= tx_go; // R6
      tx_data_o             <= tx_go ? reg_wdata_i : tx_data_o;
      transmit_enable_o     <= ctrl_d.transmit_enable;
      receive_enable_o      <= ctrl_d.receive_enable; // R8
      serial_clock_pin_o    <= bit_clk_i;
      serial_clock_pin_oe_o <= drive_ck; // R13 R14 R16
      ext_clk_sel_o         <= sel_ext; // R15 R17
      ext_clk_o             <= sck_s2_q;
    end
  end

  assign tx_empty_irq_o = req_q[pin_function_ctrl_reg_pkg::EV_TX_EMPTY];
  assign rx_full_irq_o  = req_q[pin_function_ctrl_reg_pkg::EV_RX_FULL];
  assign rx_error_irq_o = req_q[pin_function_ctrl_reg_pkg::EV_RX_ERROR];
  assign tx_end_irq_o   = req_q[pin_function_ctrl_reg_pkg::EV_TX_END];

endmodule

// File: bench/pin_function_ctrl_reg_top_asserts.sv
// Checker on the serial control register ports.
// Assumes one clock mclk_i and async active high reset_i.
`timescale 1ns/1ps
module pin_function_ctrl_reg_chk (
  input wire logic       mclk_i,
  input wire logic       reset_i,
  input wire logic       low_power_i,
  input wire logic       sync_mode_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       transmit_enable_o,
  input wire logic       tx_start_o,
  input wire logic       serial_clock_pin_oe_o,
  input wire logic       ext_clk_sel_o,
  input wire logic       tx_empty_irq_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  wire logic wc = reg_wr_i && reg_addr_i == 3'h0 && !low_power_i;
  wire logic wt = reg_wr_i && reg_addr_i == 3'h1 && !low_power_i;
  wire logic [1:0] ck = reg_wdata_i[1:0];
  property p_lp; low_power_i |=> !transmit_enable_o; endproperty
  a_lp: assert property (p_lp) else $error("ctrl kept");
  property p_te; wc |=> transmit_enable_o == $past(reg_wdata_i[5]); endproperty
  a_te: assert property (p_te) else $error("enable bad");
  property p_st; wt && transmit_enable_o |=> tx_start_o; endproperty
  a_st: assert property (p_st) else $error("no start");
  property p_ns; wt && !transmit_enable_o |=> !tx_start_o; endproperty
  a_ns: assert property (p_ns) else $error("bad start");
  property p_ti;
    wc && reg_wdata_i == 8'h80 ##1 !low_power_i |-> ##[0:2] tx_empty_irq_o;
  endproperty
  a_ti: assert property (p_ti) else $error("no tx irq");
  property p_oe;
    wc && ck == {1'b0, !sync_mode_i} |-> ##[1:2] serial_clock_pin_oe_o;
  endproperty
  a_oe: assert property (p_oe) else $error("no clk out");
  property p_nd;
    wc && !sync_mode_i && ck == 2'h0 |-> ##[1:2] !serial_clock_pin_oe_o;
  endproperty
  a_nd: assert property (p_nd) else $error("pin driven");
  property p_ex; wc && ck == 2'h2 |-> ##[1:2] ext_clk_sel_o; endproperty
  a_ex: assert property (p_ex) else $error("no ext clk");
  c_st: cover property (tx_start_o);
  c_ex: cover property (ext_clk_sel_o);
  c_ti: cover property (tx_empty_irq_o);
endmodule
bind pin_function_ctrl_reg_top pin_function_ctrl_reg_chk u_chk (.*);

// File: bench/pin_function_ctrl_reg_peer.sv
// Serial partner: datapath load and end pulses, external clock pin.
// Assumes mclk_i and reset_i of the block.
`timescale 1ns/1ps
module pin_function_ctrl_reg_peer (
  input  wire logic mclk_i,
  input  wire logic reset_i,
  input  wire logic tx_start_i,
  input  wire logic ext_clk_sel_i,
  output logic      tx_load_o,
  output logic      tx_done_o,
  output logic      pin_o
);
  logic [4:0] cnt_q;
  logic [1:0] div_q;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= 5'h00;
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
      cnt_q <= tx_start_i ? 5'h01 : cnt_q + {4'h0, cnt_q != 5'h00};
    end
  end
  assign tx_load_o = cnt_q == 5'h04;
  assign tx_done_o = cnt_q == 5'h14;
  // Pulled up unless the external clock is selected
  assign pin_o = ext_clk_sel_i ? div_q[1] : 1'b1;
endmodule

// File: bench/pin_function_ctrl_reg_top_tb.sv
// Testbench for the serial control register block.
// Assumes the peer model drives the transmit load and end pulses and clock pin.
`timescale 1ns/1ps
module pin_function_ctrl_reg_top_tb;
  logic mclk_i, reset_i, low_power_i, sync_mode_i, reg_wr_i, reg_rd_i;
  logic tx_load_i, tx_done_i, rx_done_i, rx_frame_err_i, rx_parity_err_i;
  logic rx_data_read_i, bit_clk_i, serial_clock_pin_i, serial_clock_pin_o;
  logic serial_clock_pin_oe_o, ext_clk_sel_o, ext_clk_o, tx_start_o;
  logic transmit_enable_o, receive_enable_o, tx_empty_irq_o, rx_full_irq_o;
  logic rx_error_irq_o, tx_end_irq_o, irq_o;
  logic [2:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, tx_data_o;
  logic [2:0] pin_hist;
  int error_cnt, n_tests;
  pin_function_ctrl_reg_top u_dut (.*);
  pin_function_ctrl_reg_peer u_peer (.mclk_i, .reset_i, .tx_start_i(tx_start_o),
    .ext_clk_sel_i(ext_clk_sel_o), .tx_load_o(tx_load_i),
    .tx_done_o(tx_done_i), .pin_o(serial_clock_pin_i));
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) bit_clk_i <= ~bit_clk_i;
  // Pin history: two sync stages plus the output register
  always @(posedge mclk_i) pin_hist <= {pin_hist[1:0], serial_clock_pin_i};
  task automatic ck(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 ck(reg_rdata_o, e);
  endtask
  task automatic pul(input logic [3:0] v);
    @(posedge mclk_i);
    {rx_done_i, rx_frame_err_i, rx_parity_err_i, rx_data_read_i} <= v;
    @(posedge mclk_i);
    {rx_done_i, rx_frame_err_i, rx_parity_err_i, rx_data_read_i} <= 4'h0;
    idle(2);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    {reset_i, low_power_i, sync_mode_i, reg_wr_i, reg_rd_i} = 5'h10;
    {rx_done_i, rx_frame_err_i, rx_parity_err_i, rx_data_read_i} = 4'h0;
    {reg_addr_i, reg_wdata_i, bit_clk_i} = 12'h000;
    {error_cnt, n_tests} = 0;
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    rd(3'h0, 8'h00);
    rd(3'h2, 8'h84);
    wr(3'h4, 8'h00);
    wr(3'h0, 8'h80);
    idle(2);
    ck(tx_empty_irq_o, 1'b1);
    ck(irq_o, 1'b0);
    wr(3'h4, 8'h01);
    idle(2);
    ck(irq_o, 1'b1);
    wr(3'h3, 8'h01);
    idle(2);
    ck(irq_o, 1'b0);
    wr(3'h0, 8'hA0);
    ck(transmit_enable_o, 1'b1);
    wr(3'h1, 8'h55);
    ck(tx_start_o, 1'b1);
    ck(tx_data_o, 8'h55);
    idle(2);
    ck(tx_empty_irq_o, 1'b0);
    idle(30);
    wr(3'h0, 8'h24);
    idle(2);
    ck(tx_end_irq_o, 1'b1);
    wr(3'h0, 8'h20);
    idle(2);
    ck(tx_end_irq_o, 1'b0);
    wr(3'h0, 8'h00);
    wr(3'h1, 8'hAA);
    ck(tx_start_o, 1'b0);
    $display("test transmit done");
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 3; c++) begin
        @(posedge mclk_i);
        sync_mode_i <= s[0];
        wr(3'h0, 8'(c));
        idle(2);
        ck(ext_clk_sel_o, c == 2);
        ck(serial_clock_pin_oe_o, s ? c == 0 : c == 1);
        ck(serial_clock_pin_o, !bit_clk_i);
        ck(ext_clk_o, pin_hist[2]);
      end
    end
    @(posedge mclk_i);
    low_power_i <= 1'b1;
    @(posedge mclk_i);
    low_power_i <= 1'b0;
    rd(3'h0, 8'h00);
    wr(3'h0, 8'h50);
    ck(receive_enable_o, 1'b1);
    pul(4'hC);
    ck(rx_error_irq_o, 1'b1);
    pul(4'h8);
    ck(rx_full_irq_o, 1'b1);
    wr(3'h0, 8'h40);
    ck(receive_enable_o, 1'b0);
    rd(3'h2, 8'hD4);
    pul(4'h1);
    ck(rx_full_irq_o, 1'b0);
    wr(3'h2, 8'hEF);
    idle(2);
    ck(rx_error_irq_o, 1'b0);
    pul(4'hA);
    ck(rx_error_irq_o, 1'b1);
    wr(3'h2, 8'hF7);
    idle(2);
    ck(rx_error_irq_o, 1'b0);
    pul(4'h8);
    pul(4'h8);
    rd(3'h2, 8'hE4);
    ck(rx_error_irq_o, 1'b1);
    wr(3'h2, 8'h9F);
    idle(2);
    ck(rx_full_irq_o, 1'b0);
    ck(rx_error_irq_o, 1'b0);
    $display("test receive done");
    final_report();
  end
endmodule
